// File: logic/hic_device.sv
// hic_device: helical interpolation engine behind the parallel register port
// assumes the host writes data low, data high, then the command word
`timescale 1ns/1ns
`default_nettype none
module hic_device (
    input  wire logic aclk,
    input  wire logic aresetn,
    hic_if.device     bus,
    output logic      circ_pulse,
    output logic      z_step,
    output logic      z_dir,
    output logic      u_step,
    output logic      u_dir,
    output logic      drive_active
);
    import hic_pkg::*;

    hic_dstate_t state;
    hic_dstate_t next_state;
    logic [15:0] data_lo;
    logic [15:0] data_hi;
    logic [15:0] mode;
    logic [15:0] rot;
    logic [31:0] speed;
    logic [31:0] cen_x;
    logic [31:0] cen_y;
    logic [31:0] fin_x;
    logic [31:0] fin_y;
    logic [31:0] feed_z;
    logic [31:0] feed_u;
    logic [31:0] total;
    logic [31:0] cnt;
    logic [31:0] phase;
    logic [31:0] rd_val;
    logic        calc_ccw;
    logic        err;
    logic [15:0] next_data_lo;
    logic [15:0] next_data_hi;
    logic [15:0] next_mode;
    logic [15:0] next_rot;
    logic [31:0] next_speed;
    logic [31:0] next_cen_x;
    logic [31:0] next_cen_y;
    logic [31:0] next_fin_x;
    logic [31:0] next_fin_y;
    logic [31:0] next_feed_z;
    logic [31:0] next_feed_u;
    logic [31:0] next_total;
    logic [31:0] next_cnt;
    logic [31:0] next_phase;
    logic [31:0] next_rd_val;
    logic        next_calc_ccw;
    logic        next_err;
    logic        next_circ_pulse;
    logic [15:0] next_rd_data;
    logic        cmd_stb;
    logic [7:0]  code;
    logic [3:0]  axes;
    logic [31:0] word;
    logic        z_on;
    logic        u_on;
    logic        helical_ok;
    logic        origin;
    logic [31:0] radius;
    logic [31:0] per_turn;
    logic [15:0] turns;
    logic [31:0] arc;
    logic [32:0] ph_sum;
    logic        axis_clear;

    function automatic logic [31:0] mag(input logic [31:0] v);
        mag = v[31] ? (32'h0 - v) : v;
    endfunction : mag

    assign cmd_stb    = bus.wr_stb && (bus.wr_addr == ADDR_CMD);
    assign code       = bus.wr_data[7:0];
    assign axes       = bus.wr_data[11:8];
    assign word       = {data_hi, data_lo};
    assign z_on       = (mode[3:0] == 4'h7) || (mode[3:0] == 4'hf);
    assign u_on       = (mode[3:0] == 4'hb) || (mode[3:0] == 4'hf);
    assign helical_ok = mode[AX_X] && mode[AX_Y] && (z_on || u_on);
    assign origin     = (fin_x == 32'h0) && (fin_y == 32'h0);
    assign radius     = (mag(cen_x) > mag(cen_y)) ? mag(cen_x) : mag(cen_y);
    assign per_turn   = {radius[28:0], 3'h0};
    assign turns      = (origin && (rot < 16'h2)) ? 16'h1 : rot;
    assign arc        = origin ? 32'h0 : (mag(fin_x) + mag(fin_y));
    assign ph_sum     = {1'b0, phase} + {1'b0, speed};
    // the last circle pulse lands with state idle and must still step
    assign axis_clear = (state == DS_IDLE) && !circ_pulse;

    always_comb begin
        next_state      = state;
        next_data_lo    = data_lo;
        next_data_hi    = data_hi;
        next_mode       = mode;
        next_rot        = rot;
        next_speed      = speed;
        next_cen_x      = cen_x;
        next_cen_y      = cen_y;
        next_fin_x      = fin_x;
        next_fin_y      = fin_y;
        next_feed_z     = feed_z;
        next_feed_u     = feed_u;
        next_total      = total;
        next_cnt        = cnt;
        next_phase      = phase;
        next_rd_val     = rd_val;
        next_calc_ccw   = calc_ccw;
        next_err        = err;
        next_circ_pulse = 1'b0;
        if (bus.wr_stb && (bus.wr_addr == ADDR_LO)) begin
            next_data_lo = bus.wr_data;
        end else if (bus.wr_stb && (bus.wr_addr == ADDR_HI)) begin
            next_data_hi = bus.wr_data;
        end
        case (state)
            DS_IDLE: begin
                if (cmd_stb) begin
                    case (code)
                        CMD_MODE: next_mode = data_lo;
                        CMD_ROTATION: next_rot = data_lo;
                        CMD_SPEED: begin
                            if (axes[AX_X]) begin
                                next_speed = word;
                            end
                        end
                        CMD_CENTER: begin
                            if (axes[AX_X]) begin
                                next_cen_x = word;
                            end
                            if (axes[AX_Y]) begin
                                next_cen_y = word;
                            end
                        end
                        CMD_FINISH: begin
                            if (axes[AX_X]) begin
                                next_fin_x = word;
                            end
                            if (axes[AX_Y]) begin
                                next_fin_y = word;
                            end
                            if (axes[AX_Z]) begin
                                next_feed_z = word;
                            end
                            if (axes[AX_U]) begin
                                next_feed_u = word;
                            end
                        end
                        CMD_CALC_CW, CMD_CALC_CCW: begin
                            next_calc_ccw = (code == CMD_CALC_CCW);
                            next_err      = !helical_ok;
                            next_total    = arc;
                            next_cnt      = 32'h0;
                            if (helical_ok) begin
                                next_state = DS_CALC;
                            end
                        end
                        CMD_READ_CALC: next_rd_val = total;
                        CMD_DRIVE_CW, CMD_DRIVE_CCW: begin
                            next_err = !helical_ok || !mode[EQ_BIT]
                                || (calc_ccw != (code == CMD_DRIVE_CCW));
                            next_cnt   = 32'h0;
                            next_phase = 32'h0;
                            if (!next_err && (total != 32'h0)) begin
                                next_state = DS_DRIVE;
                            end
                        end
                        default: next_err = err;
                    endcase
                end
            end
            DS_CALC: begin
                if (cnt[15:0] < turns) begin
                    next_total = total + per_turn;
                    next_cnt   = cnt + 32'h1;
                end else begin
                    next_state = DS_IDLE;
                end
            end
            DS_DRIVE: begin
                if (ph_sum >= CLK_HZ_W) begin
                    next_phase      = 32'(ph_sum - CLK_HZ_W);
                    next_circ_pulse = 1'b1;
                    next_cnt        = cnt + 32'h1;
                    if (next_cnt == total) begin
                        next_state = DS_IDLE;
                    end
                end else begin
                    next_phase = ph_sum[31:0];
                end
            end
            default: next_state = DS_IDLE;
        endcase
    end

    always_comb begin
        if (bus.rd_addr == ADDR_STATUS) begin
            next_rd_data = {11'h0, err,
                            (state == DS_DRIVE) && u_on,
                            (state == DS_DRIVE) && z_on,
                            state != DS_IDLE, state != DS_IDLE};
        end else if (bus.rd_addr == ADDR_LO) begin
            next_rd_data = rd_val[15:0];
        end else if (bus.rd_addr == ADDR_HI) begin
            next_rd_data = rd_val[31:16];
        end else begin
            next_rd_data = 16'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= DS_IDLE;
            data_lo     <= 16'h0;
            data_hi     <= 16'h0;
            mode        <= MODE_RESET;
            rot         <= 16'h0;
            speed       <= 32'h0;
            cen_x       <= 32'h0;
            cen_y       <= 32'h0;
            fin_x       <= 32'h0;
            fin_y       <= 32'h0;
            feed_z      <= 32'h0;
            feed_u      <= 32'h0;
            total       <= 32'h0;
            cnt         <= 32'h0;
            phase       <= 32'h0;
            rd_val      <= 32'h0;
            calc_ccw    <= 1'b0;
            err         <= 1'b0;
            circ_pulse  <= 1'b0;
            bus.rd_data <= 16'h0;
        end else begin
            state       <= next_state;
            data_lo     <= next_data_lo;
            data_hi     <= next_data_hi;
            mode        <= next_mode;
            rot         <= next_rot;
            speed       <= next_speed;
            cen_x       <= next_cen_x;
            cen_y       <= next_cen_y;
            fin_x       <= next_fin_x;
            fin_y       <= next_fin_y;
            feed_z      <= next_feed_z;
            feed_u      <= next_feed_u;
            total       <= next_total;
            cnt         <= next_cnt;
            phase       <= next_phase;
            rd_val      <= next_rd_val;
            calc_ccw    <= next_calc_ccw;
            err         <= next_err;
            circ_pulse  <= next_circ_pulse;
            bus.rd_data <= next_rd_data;
        end
    end

    assign drive_active = (state == DS_DRIVE);
    assign z_dir        = feed_z[31];
    assign u_dir        = feed_u[31];

    // synchronized axes, rate set by circle pulses, feed and total
    hic_axis u_axis_z (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (axis_clear),
        .pulse   (circ_pulse),
        .feed    (z_on ? mag(feed_z) : 32'h0),
        .total   (total),
        .step    (z_step)
    );

    hic_axis u_axis_u (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (axis_clear),
        .pulse   (circ_pulse),
        .feed    (u_on ? mag(feed_u) : 32'h0),
        .total   (total),
        .step    (u_step)
    );
endmodule : hic_device
`default_nettype wire

// File: logic/hic_pkg.sv
// hic_pkg: shared constants for the helical interpolation controller
// assumes a 100 MHz aclk and a synchronous active-low reset
package hic_pkg;
    localparam logic [2:0]  ADDR_CMD      = 3'h0;
    localparam logic [2:0]  ADDR_STATUS   = 3'h0;
    localparam logic [2:0]  ADDR_LO       = 3'h6;
    localparam logic [2:0]  ADDR_HI       = 3'h7;
    localparam logic [7:0]  CMD_SPEED     = 8'h05;
    localparam logic [7:0]  CMD_FINISH    = 8'h06;
    localparam logic [7:0]  CMD_CENTER    = 8'h08;
    localparam logic [7:0]  CMD_ROTATION  = 8'h1a;
    localparam logic [7:0]  CMD_MODE      = 8'h2a;
    localparam logic [7:0]  CMD_READ_CALC = 8'h3b;
    localparam logic [7:0]  CMD_DRIVE_CW  = 8'h64;
    localparam logic [7:0]  CMD_DRIVE_CCW = 8'h65;
    localparam logic [7:0]  CMD_CALC_CW   = 8'h6b;
    localparam logic [7:0]  CMD_CALC_CCW  = 8'h6c;
    localparam int          AX_X          = 0;
    localparam int          AX_Y          = 1;
    localparam int          AX_Z          = 2;
    localparam int          AX_U          = 3;
    localparam int          EQ_BIT        = 8;
    localparam int          ERR_BIT       = 4;
    localparam int          CLK_HZ        = 100000000;
    localparam logic [32:0] CLK_HZ_W      = 33'(CLK_HZ);
    localparam logic [15:0] MODE_RESET    = 16'h0000;
    localparam logic [7:0]  AXI_CMD       = 8'h00;
    localparam logic [7:0]  AXI_DATA      = 8'h04;
    localparam logic [7:0]  AXI_STATUS    = 8'h08;
    localparam logic [7:0]  AXI_RESULT    = 8'h0c;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    typedef enum logic [1:0] {
        DS_IDLE  = 2'b00,
        DS_CALC  = 2'b01,
        DS_DRIVE = 2'b10
    } hic_dstate_t;
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_LO    = 3'b001,
        HS_HI    = 3'b010,
        HS_CMD   = 3'b011,
        HS_RLO   = 3'b100,
        HS_RHI   = 3'b101,
        HS_RDONE = 3'b110
    } hic_hstate_t;
endpackage : hic_pkg

// File: logic/hic_if.sv
// hic_if: parallel register port between host and device
// assumes both ends share aclk; testbench instantiates and joins them
`timescale 1ns/1ns
`default_nettype none
interface hic_if;
    logic        wr_stb;
    logic [2:0]  wr_addr;
    logic [15:0] wr_data;
    logic [2:0]  rd_addr;
    logic [15:0] rd_data;
    modport device (input wr_stb, wr_addr, wr_data, rd_addr, output rd_data);
    modport host   (output wr_stb, wr_addr, wr_data, rd_addr, input rd_data);
endinterface : hic_if
`default_nettype wire

// File: logic/hic_axis.sv
// hic_axis: one synchronized axis, stepped in proportion to circle pulses
// assumes feed magnitude below total and clear before each drive
`timescale 1ns/1ns
`default_nettype none
module hic_axis (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clear,
    input  wire logic        pulse,
    input  wire logic [31:0] feed,
    input  wire logic [31:0] total,
    output logic             step
);
    logic [32:0] acc;
    logic [32:0] next_acc;
    logic        next_step;
    logic [32:0] sum;

    always_comb begin
        sum       = acc + {1'b0, feed};
        next_acc  = acc;
        next_step = 1'b0;
        if (clear) begin
            next_acc = 33'h0;
        end else if (pulse) begin
            if (sum >= {1'b0, total}) begin
                next_acc  = sum - {1'b0, total};
                next_step = 1'b1;
            end else begin
                next_acc = sum;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc  <= 33'h0;
            step <= 1'b0;
        end else begin
            acc  <= next_acc;
            step <= next_step;
        end
    end
endmodule : hic_axis
`default_nettype wire

// File: logic/hic_host.sv
// hic_host: AXI4-Lite slave that relays software commands to the device port
// assumes software follows the documented command order
`timescale 1ns/1ns
`default_nettype none
module hic_host (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    hic_if.host              bus,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import hic_pkg::*;

    hic_hstate_t hs;
    hic_hstate_t next_hs;
    logic [31:0] data;
    logic [15:0] cmd;
    logic [15:0] status;
    logic [31:0] result;
    logic [31:0] next_data;
    logic [15:0] next_cmd;
    logic [15:0] next_status;
    logic [31:0] next_result;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [1:0]  next_rresp;
    logic [31:0] next_rdata;
    logic        wtake;

    assign wtake         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && (hs == HS_IDLE);
    assign s_axi_awready = wtake;
    assign s_axi_wready  = wtake;
    assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;

    always_comb begin
        next_hs     = hs;
        next_data   = data;
        next_cmd    = cmd;
        next_status = status;
        next_result = result;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp  = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp  = s_axi_rresp;
        next_rdata  = s_axi_rdata;
        if (wtake) begin
            next_bvalid = 1'b1;
            next_bresp  = RESP_OKAY;
            if (s_axi_awaddr == AXI_CMD) begin
                next_cmd = s_axi_wdata[15:0];
                next_hs  = HS_LO;
            end else if (s_axi_awaddr == AXI_DATA) begin
                for (int i = 0; i < 4; i++) begin
                    if (s_axi_wstrb[i]) begin
                        next_data[8*i +: 8] = s_axi_wdata[8*i +: 8];
                    end
                end
            end else begin
                next_bresp = RESP_SLVERR;
            end
        end
        if (s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            if (s_axi_araddr == AXI_CMD) begin
                next_rdata = 32'h0;
            end else if (s_axi_araddr == AXI_DATA) begin
                next_rdata = data;
            end else if (s_axi_araddr == AXI_STATUS) begin
                next_rdata = {15'h0, hs != HS_IDLE, status};
            end else if (s_axi_araddr == AXI_RESULT) begin
                next_rdata = result;
            end else begin
                next_rdata = 32'h0;
                next_rresp = RESP_SLVERR;
            end
        end
        case (hs)
            HS_IDLE: next_status = bus.rd_data;
            HS_LO: next_hs = HS_HI;
            HS_HI: next_hs = HS_CMD;
            HS_CMD: next_hs = (cmd[7:0] == CMD_READ_CALC) ? HS_RLO : HS_IDLE;
            HS_RLO: next_hs = HS_RHI;
            HS_RHI: begin
                next_result[15:0] = bus.rd_data;
                next_hs           = HS_RDONE;
            end
            HS_RDONE: begin
                next_result[31:16] = bus.rd_data;
                next_hs            = HS_IDLE;
            end
            default: next_hs = HS_IDLE;
        endcase
    end

    always_comb begin
        bus.wr_stb  = (hs == HS_LO) || (hs == HS_HI) || (hs == HS_CMD);
        bus.wr_addr = (hs == HS_LO) ? ADDR_LO : ((hs == HS_HI) ? ADDR_HI : ADDR_CMD);
        bus.wr_data = (hs == HS_LO) ? data[15:0] : ((hs == HS_HI) ? data[31:16] : cmd);
        bus.rd_addr = (hs == HS_RLO) ? ADDR_LO : ((hs == HS_RHI) ? ADDR_HI : ADDR_STATUS);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs           <= HS_IDLE;
            data         <= 32'h0;
            cmd          <= 16'h0;
            status       <= 16'h0;
            result       <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0;
        end else begin
            hs           <= next_hs;
            data         <= next_data;
            cmd          <= next_cmd;
            status       <= next_status;
            result       <= next_result;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp  <= next_rresp;
            s_axi_rdata  <= next_rdata;
        end
    end
endmodule : hic_host
`default_nettype wire

// File: verif/hic_chk_assertions.sv
// hic_chk: concurrent checks on the host-device port and drive outputs
// assumes instantiation beside hic_if in testbench, one clock domain
`timescale 1ns/1ns
`default_nettype none
module hic_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        wr_stb,
    input wire logic [2:0]  wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [2:0]  rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic        circ_pulse,
    input wire logic        z_step,
    input wire logic        u_step,
    input wire logic        drive_active
);
    import hic_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_hi;
        wr_stb && wr_addr == ADDR_HI;
    endsequence
    sequence s_cmd;
        wr_stb && wr_addr == ADDR_CMD;
    endsequence
    a_word_order: assert property (wr_stb && wr_addr == ADDR_LO |=> s_hi ##1 s_cmd)
        else $error("data words out of order");
    a_hi_first: assert property (s_hi |-> $past(wr_stb) && $past(wr_addr) == ADDR_LO)
        else $error("high word without low word");
    a_cmd_single: assert property (s_cmd |=> !wr_stb)
        else $error("command strobe longer than one cycle");
    a_read_back: assert property (wr_stb && wr_addr == ADDR_CMD && wr_data[7:0] == CMD_READ_CALC
        |=> rd_addr == ADDR_LO ##1 rd_addr == ADDR_HI) else $error("result not read back");
    a_xy_paired: assert property ($past(rd_addr) == ADDR_STATUS |-> rd_data[0] == rd_data[1])
        else $error("x and y active bits differ");
    a_z_follows: assert property (z_step |-> $past(circ_pulse))
        else $error("z step without circle pulse");
    a_u_follows: assert property (u_step |-> $past(circ_pulse))
        else $error("u step without circle pulse");
    a_circ_drive: assert property (circ_pulse |-> drive_active || $past(drive_active))
        else $error("circle pulse outside drive");
endmodule : hic_chk
`default_nettype wire

// File: verif/testbench.sv
// testbench: drives hic_host over AXI4-Lite with hic_device behind it
// assumes one 100 MHz clock and the package command codes
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import hic_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, d, tot, f, g, cx, st = 32'hc27d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        circ_pulse, z_step, z_dir, u_step, u_dir, drive_active;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata;
    int          error_cnt = 0, comparisons = 0, cyc = 0, nc, nz, nu;
    int          rots[5] = '{1000, 5, 2, 1, 0};
    hic_if hif ();
    hic_host u_hic_host (.bus(hif.host), .*);
    hic_device u_hic_device (.bus(hif.device), .*);
    hic_chk u_hic_chk (.wr_stb(hif.wr_stb), .wr_addr(hif.wr_addr), .wr_data(hif.wr_data),
        .rd_addr(hif.rd_addr), .rd_data(hif.rd_data), .*);
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        nc += circ_pulse;
        nz += z_step;
        nu += u_step;
        if (cyc == 90000) begin
            error_cnt++;
            give_verdict();
        end
    end
    function automatic logic [31:0] rnd();
        st = {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
        return st;
    endfunction : rnd
    function automatic logic [31:0] exp_tot(logic [31:0] c, logic [31:0] n);
        return 32'h8 * c * ((n < 2) ? 32'h1 : n);
    endfunction : exp_tot
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic wr(logic [7:0] a, logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
    endtask : wr
    task automatic rd(logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
    task automatic cmd(logic [7:0] c, logic [3:0] ax, logic [31:0] v);
        wr(AXI_DATA, v);
        wr(AXI_CMD, {20'h0, ax, c});
    endtask : cmd
    // host sequence lasts up to 6 cycles; wait 8, then poll until both ends are idle
    task automatic idle();
        repeat (8) @(posedge aclk);
        do rd(AXI_STATUS); while (d[16] !== 1'h0 || d[1:0] !== 2'h0);
    endtask : idle
    task automatic drv(logic [3:0] m, logic [7:0] c);
        cmd(CMD_MODE, 4'h0, {20'h0, 4'h1, 4'h0, m});
        cmd(CMD_SPEED, 4'h1, 32'h3d090);
        cmd(CMD_ROTATION, 4'h0, 32'h0);
        cmd(CMD_CENTER, 4'h1, cx);
        cmd(CMD_CENTER, 4'h2, 32'h0);
        cmd(CMD_FINISH, 4'h1, 32'h0);
        cmd(CMD_FINISH, 4'h2, 32'h0);
        cmd(CMD_FINISH, 4'h4, f);
        cmd(CMD_FINISH, 4'h8, -g);
        nc = 0;
        nz = 0;
        nu = 0;
        wr(AXI_CMD, {24'h0, c});
        idle();
    endtask : drv
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(AXI_STATUS);
        chk("status_reset", d, 32'h0);
        rd(8'h10);
        chk("unmapped_rd", {d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(8'h14, 32'h0);
        chk("unmapped_wr", {30'h0, r}, {30'h0, RESP_SLVERR});
        cx = 32'h1 + rnd() % 4;
        cmd(CMD_MODE, 4'h0, 32'h10f);
        cmd(CMD_SPEED, 4'h1, 32'h3d090);
        cmd(CMD_CENTER, 4'h1, cx);
        cmd(CMD_CENTER, 4'h2, 32'h0);
        cmd(CMD_FINISH, 4'h1, 32'h0);
        cmd(CMD_FINISH, 4'h2, 32'h0);
        foreach (rots[i]) begin
            cmd(CMD_ROTATION, 4'h0, rots[i]);
            cmd(CMD_CALC_CW, 4'h0, 32'h0);
            if (i == 0) begin
                repeat (20) @(posedge aclk);
                rd(AXI_STATUS);
                chk("calc_busy", {30'h0, d[1:0]}, 32'h3);
            end
            idle();
            cmd(CMD_READ_CALC, 4'h0, 32'h0);
            idle();
            rd(AXI_RESULT);
            chk("total", d, exp_tot(cx, rots[i]));
        end
        tot = exp_tot(cx, 32'h0);
        f = 32'h1 + rnd() % (tot - 1);
        g = 32'h1 + rnd() % (tot - 1);
        drv(4'hf, CMD_DRIVE_CW);
        chk("circ_cnt", nc, tot);
        chk("z_cnt", nz, f);
        chk("u_cnt", nu, g);
        chk("dirs", {30'h0, z_dir, u_dir}, 32'h1);
        drv(4'hb, CMD_DRIVE_CW);
        chk("u_only_z", nz, 32'h0);
        chk("u_only_u", nu, g);
        drv(4'hb, CMD_DRIVE_CCW);
        chk("dir_mismatch", nc, 32'h0);
        cmd(CMD_CALC_CCW, 4'h0, 32'h0);
        idle();
        drv(4'h7, CMD_DRIVE_CCW);
        chk("z_only_u", nu, 32'h0);
        chk("z_only_z", nz, f);
        drv(4'h3, CMD_DRIVE_CCW);
        chk("no_sync_axis", nc, 32'h0);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
